// ==== verilog/slt_defines.svh ====
// Constants for the serial link transmit setup block and its controller.
// Assumes inclusion by bare name from both ends, the checker and the testbench.
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH
// Device register offsets
`define SLT_SOFT_RESET_OFS   16'h0000
`define SLT_DP_RESET_OFS     16'h0001
`define SLT_POWER_MODE_OFS   16'h0002
`define SLT_DECIM_OFS        16'h0201
`define SLT_FORMAT_OFS       16'h0561
`define SLT_LANE_RATE_OFS    16'h056e
`define SLT_PLL_STATUS_OFS   16'h056f
`define SLT_TAIL_CTRL_OFS    16'h0570
`define SLT_LINK_CTRL_OFS    16'h0571
`define SLT_DRIVER_CTRL_OFS  16'h05c4
`define SLT_PLL_CTRL_OFS     16'h1222
`define SLT_STARTUP_OFS      16'h1228
`define SLT_LOCK_CLR_OFS     16'h1262
// Reset values
`define SLT_LANE_RATE_RST    8'h10
`define SLT_DECIM_RST        8'h01
`define SLT_STARTUP_RST      8'h0f
`define SLT_ZERO_RST         8'h00
// Command codes and field positions
`define SLT_SOFT_RESET_CODE  8'h81
`define SLT_DP_RESET_CODE    8'h02
`define SLT_LOCK_BIT         7
`define SLT_LOL_BIT          3
`define SLT_RESTART_BIT      0
`define SLT_LOCK_CLR_BIT     3
`define SLT_PRN_BIT          2
`define SLT_CS_LSB           4
`define SLT_DEEMPH_BIT       0
`define SLT_OFFSET_BIN_BIT   0
`define SLT_K28_5            8'hbc
`define SLT_PRN_SEED         15'h7fff
// Initialisation sequence
`define SLT_INIT_STARTUP_RST 8'h4f
`define SLT_INIT_STARTUP_RUN 8'h0f
`define SLT_INIT_PLL_NORMAL  8'h00
`define SLT_INIT_PLL_CAL_RST 8'h04
`define SLT_INIT_LOL_CLEAR   8'h08
`define SLT_INIT_LOL_NORMAL  8'h00
`define SLT_INIT_STEPS       3'd7
// Controller Avalon word indexes
`define SLT_HC_CTRL_IDX      2'd0
`define SLT_HC_ACCESS_IDX    2'd1
`define SLT_HC_STATUS_IDX    2'd2
`define SLT_HC_LANES_IDX     2'd3
`define SLT_HC_START_BIT     0
`define SLT_HC_SYNC_BIT      1
`define SLT_HC_GO_BIT        2
`define SLT_HC_RNW_BIT       3
`endif

// ==== verilog/slt_pkg.sv ====
// Types shared by both ends of the serial link transmit setup block.
// Assumes slt_defines.svh for the numeric constants.
package slt_pkg;
  typedef enum logic [1:0] {
    SLT_HS_IDLE = 2'b00,
    SLT_HS_INIT = 2'b01,
    SLT_HS_ONE  = 2'b10,
    SLT_HS_WAIT = 2'b11
  } slt_host_state_t;

  typedef struct packed {
    logic [7:0]       power_mode;
    logic [7:0]       decim;
    logic [7:0]       format;
    logic [7:0]       lane_rate;
    logic [7:0]       tail_ctrl;
    logic [7:0]       link_ctrl;
    logic [7:0]       driver_ctrl;
    logic [7:0]       pll_ctrl;
    logic [7:0]       startup;
    logic [7:0]       lock_clr;
    logic             lock_loss_flag;
    logic [2:0]       lock_sync;
    logic [2:0]       pdn_sync;
    logic             lock_prev;
    logic             ack;
    logic [7:0]       rdata;
    logic [7:0]       dcnt;
    logic [14:0]      prn;
    logic [3:0][7:0]  octet;
    logic [3:0]       kflag;
    logic [3:0]       lane_on;
    logic             strobe;
  } slt_dev_state_t;

  typedef struct packed {
    slt_host_state_t  st;
    logic [2:0]       step;
    logic             sync_req;
    logic             rnw;
    logic [15:0]      acc_addr;
    logic [7:0]       acc_wdata;
    logic [7:0]       acc_rdata;
    logic             wr;
    logic             rd;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic [31:0]      lanes;
    logic             rd_done;
    logic [31:0]      readdata;
  } slt_host_state_s_t;
endpackage : slt_pkg

// ==== verilog/slt_link_if.sv ====
// Link between the transmit device and its controller: register port plus lanes.
// Assumes both ends on the same sys_clk.
`timescale 1ns/1ps
interface slt_link_if;
  // Register access
  logic [15:0]      cfg_addr;
  logic [7:0]       cfg_wdata;
  logic             cfg_wr;
  logic             cfg_rd;
  logic [7:0]       cfg_rdata;
  logic             cfg_ack;
  // Serial lanes, one octet per lane per strobe
  logic [3:0][7:0]  lane_octet;
  logic [3:0]       lane_k;
  logic [3:0]       lane_on;
  logic             lane_strobe;
  logic             sync_request_input_n;

  modport dev (input cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sync_request_input_n,
               output cfg_rdata, cfg_ack, lane_octet, lane_k, lane_on, lane_strobe);
  modport host (output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sync_request_input_n,
                input cfg_rdata, cfg_ack, lane_octet, lane_k, lane_on, lane_strobe);
endinterface : slt_link_if

// ==== verilog/slt_device.sv ====
// Transmit end: configuration registers, PLL status, sample framing onto 4 lanes.
// Assumes the controller holds a register request until cfg_ack, same clock.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "slt_defines.svh"
module slt_device (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Link to controller
  slt_link_if.dev           link,
  // Converter samples and control-bit sources
  input  wire logic [13:0]  sample_a,
  input  wire logic [13:0]  sample_b,
  input  wire logic [1:0]   over_range,
  input  wire logic         sysref_seen,
  input  wire logic [1:0]   fast_detect,
  // Serializer PLL and power pin
  input  wire logic         pll_locked,
  input  wire logic         power_down_pin,
  // Analog-side controls
  output logic              deemph_en,
  output logic [3:0]        lane_rate_code,
  output logic              pll_cal_reset,
  output logic              startup_reset
);
  import slt_pkg::*;

  slt_dev_state_t s_reg;
  slt_dev_state_t s_next;

  // Two virtual converters, one per input; DDC use would raise this count
  localparam logic [3:0] M_CONV = 4'd2;

  function automatic logic [7:0] status_byte(input logic lk, input logic lock_loss_flag);
    status_byte = 8'h00;
    status_byte[`SLT_LOCK_BIT] = lk;
    status_byte[`SLT_LOL_BIT] = lock_loss_flag;
  endfunction : status_byte

  // Build both octets of one sample: coding, control bits, tail
  function automatic logic [15:0] frame_word(input logic [13:0] smp,
                                             input logic offs, input logic [1:0] cs,
                                             input logic [1:0] cb, input logic [1:0] tail);
    logic [13:0] v;
    logic [1:0]  t;
    v = smp;
    t = tail;
    if (offs) begin
      v[13] = ~smp[13];
    end
    // Only two tail slots exist at N=14, so a count of 3 acts as 2
    if (cs != 2'd0) begin
      t[1] = cb[1];
    end
    if (cs[1]) begin
      t[0] = cb[0];
    end
    frame_word = {v, t};
  endfunction : frame_word

  logic        cfg_hit;
  logic        lock_lvl;
  logic        pdn_lvl;
  logic        loss;
  logic [7:0]  ratio;
  logic [1:0]  cs;
  logic [1:0]  tail_bits;
  logic [1:0]  cb_a;
  logic [1:0]  cb_b;
  logic [15:0] word_a;
  logic [15:0] word_b;

  always_comb begin
    s_next = s_reg;
    cfg_hit = (link.cfg_wr | link.cfg_rd) & ~s_reg.ack;
    s_next.ack = cfg_hit;
    // Stable once the second and third stages agree
    s_next.lock_sync = {s_reg.lock_sync[1:0], pll_locked};
    s_next.pdn_sync = {s_reg.pdn_sync[1:0], power_down_pin};
    lock_lvl = s_reg.lock_prev;
    if (s_reg.lock_sync[1] == s_reg.lock_sync[2]) begin
      lock_lvl = s_reg.lock_sync[2];
    end
    pdn_lvl = s_reg.pdn_sync[2] & s_reg.pdn_sync[1];
    s_next.lock_prev = lock_lvl;
    loss = s_reg.lock_prev & ~lock_lvl;
    s_next.strobe = 1'b0;
    // Register reads
    if (cfg_hit && link.cfg_rd) begin
      unique case (link.cfg_addr)
        `SLT_POWER_MODE_OFS:  s_next.rdata = s_reg.power_mode;
        `SLT_DECIM_OFS:       s_next.rdata = s_reg.decim;
        `SLT_FORMAT_OFS:      s_next.rdata = s_reg.format;
        `SLT_LANE_RATE_OFS:   s_next.rdata = s_reg.lane_rate;
        `SLT_PLL_STATUS_OFS:  s_next.rdata = status_byte(lock_lvl, s_reg.lock_loss_flag);
        `SLT_TAIL_CTRL_OFS:   s_next.rdata = s_reg.tail_ctrl;
        `SLT_LINK_CTRL_OFS:   s_next.rdata = s_reg.link_ctrl;
        `SLT_DRIVER_CTRL_OFS: s_next.rdata = s_reg.driver_ctrl;
        `SLT_PLL_CTRL_OFS:    s_next.rdata = s_reg.pll_ctrl;
        `SLT_STARTUP_OFS:     s_next.rdata = s_reg.startup;
        `SLT_LOCK_CLR_OFS:    s_next.rdata = s_reg.lock_clr;
        default:              s_next.rdata = 8'h00;
      endcase
    end
    // Register writes; reset controls self-clear and read zero
    if (cfg_hit && link.cfg_wr) begin
      unique case (link.cfg_addr)
        `SLT_SOFT_RESET_OFS: begin
          if (link.cfg_wdata == `SLT_SOFT_RESET_CODE) begin
            s_next.power_mode = `SLT_ZERO_RST;
            s_next.decim = `SLT_DECIM_RST;
            s_next.format = `SLT_ZERO_RST;
            s_next.lane_rate = `SLT_LANE_RATE_RST;
            s_next.tail_ctrl = `SLT_ZERO_RST;
            s_next.link_ctrl = `SLT_ZERO_RST;
            s_next.driver_ctrl = `SLT_ZERO_RST;
            s_next.pll_ctrl = `SLT_ZERO_RST;
            s_next.startup = `SLT_STARTUP_RST;
            s_next.lock_clr = `SLT_ZERO_RST;
          end
        end
        `SLT_DP_RESET_OFS: begin
          if (link.cfg_wdata == `SLT_DP_RESET_CODE) begin
            s_next.prn = `SLT_PRN_SEED;
            s_next.dcnt = 8'h00;
          end
        end
        `SLT_POWER_MODE_OFS:  s_next.power_mode = link.cfg_wdata;
        `SLT_DECIM_OFS:       s_next.decim = link.cfg_wdata;
        `SLT_FORMAT_OFS:      s_next.format = link.cfg_wdata;
        `SLT_LANE_RATE_OFS:   s_next.lane_rate = link.cfg_wdata;
        `SLT_TAIL_CTRL_OFS:   s_next.tail_ctrl = link.cfg_wdata;
        `SLT_LINK_CTRL_OFS: begin
          s_next.link_ctrl = link.cfg_wdata;
          if (s_reg.link_ctrl[`SLT_RESTART_BIT] && !link.cfg_wdata[`SLT_RESTART_BIT]) begin
            s_next.lock_loss_flag = 1'b0;
          end
        end
        `SLT_DRIVER_CTRL_OFS: s_next.driver_ctrl = link.cfg_wdata;
        `SLT_PLL_CTRL_OFS:    s_next.pll_ctrl = link.cfg_wdata;
        `SLT_STARTUP_OFS:     s_next.startup = link.cfg_wdata;
        `SLT_LOCK_CLR_OFS: begin
          s_next.lock_clr = link.cfg_wdata;
          if (link.cfg_wdata[`SLT_LOCK_CLR_BIT]) begin
            s_next.lock_loss_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A loss in the clearing cycle must survive the clear
    if (loss) begin
      s_next.lock_loss_flag = 1'b1;
    end
    // Output sample rate is the clock divided by the decimation ratio
    ratio = (s_reg.decim == 8'h00) ? 8'h01 : s_reg.decim;
    if (s_reg.dcnt >= ratio - 8'h01) begin
      s_next.dcnt = 8'h00;
      s_next.strobe = 1'b1;
    end else begin
      s_next.dcnt = s_reg.dcnt + 8'h01;
    end
    // Lanes stay up unless a power control or the link restart bit takes them down
    s_next.lane_on = (s_reg.power_mode[1:0] == 2'b00 && !pdn_lvl
                      && !s_reg.link_ctrl[`SLT_RESTART_BIT]) ? 4'hf : 4'h0;
    cs = s_reg.tail_ctrl[`SLT_CS_LSB +: 2];
    tail_bits = s_reg.tail_ctrl[`SLT_PRN_BIT] ? s_reg.prn[1:0] : 2'b00;
    // Control bit 2 overrange, bit 1 SYSREF; fast detect gets no control bit
    cb_a = {over_range[0], sysref_seen};
    cb_b = {over_range[1], sysref_seen};
    word_a = frame_word(sample_a, s_reg.format[`SLT_OFFSET_BIN_BIT], cs, cb_a, tail_bits);
    word_b = frame_word(sample_b, s_reg.format[`SLT_OFFSET_BIN_BIT], cs, cb_b, tail_bits);
    if (s_next.strobe) begin
      s_next.prn = {s_reg.prn[13:0], s_reg.prn[14] ^ s_reg.prn[13]};
      if (!link.sync_request_input_n) begin
        s_next.octet = {4{`SLT_K28_5}};
        s_next.kflag = 4'hf;
      end else begin
        s_next.octet = {word_b[7:0], word_b[15:8], word_a[7:0], word_a[15:8]};
        s_next.kflag = 4'h0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.decim <= `SLT_DECIM_RST;
      s_reg.lane_rate <= `SLT_LANE_RATE_RST;
      s_reg.startup <= `SLT_STARTUP_RST;
      s_reg.driver_ctrl <= `SLT_ZERO_RST;
      s_reg.prn <= `SLT_PRN_SEED;
      s_reg.lane_on <= 4'hf;
      s_reg.kflag <= 4'hf;
      s_reg.octet <= {4{`SLT_K28_5}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.cfg_ack = s_reg.ack;
  assign link.cfg_rdata = s_reg.rdata;
  assign link.lane_octet = s_reg.octet;
  assign link.lane_k = s_reg.kflag;
  assign link.lane_on = s_reg.lane_on;
  assign link.lane_strobe = s_reg.strobe;
  assign deemph_en = s_reg.driver_ctrl[`SLT_DEEMPH_BIT];
  assign lane_rate_code = s_reg.lane_rate[7:4];
  assign pll_cal_reset = s_reg.pll_ctrl[2];
  assign startup_reset = s_reg.startup[6];
endmodule : slt_device

// ==== verilog/slt_host.sv ====
// Controller end: Avalon-MM slave registers, initialisation sequencer, lane capture.
// Assumes the device acks each register request once, same clock.
`timescale 1ns/1ps
`include "slt_defines.svh"
module slt_host (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Link to device
  slt_link_if.host          link,
  // Avalon-MM slave
  input  wire logic [1:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest
);
  import slt_pkg::*;

  slt_host_state_s_t s_reg;
  slt_host_state_s_t s_next;

  // Fixed initialisation writes, in the only order the link accepts
  function automatic logic [23:0] init_step(input logic [2:0] idx);
    unique case (idx)
      3'd0:    init_step = {`SLT_STARTUP_OFS, `SLT_INIT_STARTUP_RST};
      3'd1:    init_step = {`SLT_STARTUP_OFS, `SLT_INIT_STARTUP_RUN};
      3'd2:    init_step = {`SLT_PLL_CTRL_OFS, `SLT_INIT_PLL_NORMAL};
      3'd3:    init_step = {`SLT_PLL_CTRL_OFS, `SLT_INIT_PLL_CAL_RST};
      3'd4:    init_step = {`SLT_PLL_CTRL_OFS, `SLT_INIT_PLL_NORMAL};
      3'd5:    init_step = {`SLT_LOCK_CLR_OFS, `SLT_INIT_LOL_CLEAR};
      default: init_step = {`SLT_LOCK_CLR_OFS, `SLT_INIT_LOL_NORMAL};
    endcase
  endfunction : init_step

  logic busy;

  always_comb begin
    s_next = s_reg;
    busy = (s_reg.st != SLT_HS_IDLE);
    s_next.rd_done = 1'b0;
    if (avs_read && !s_reg.rd_done) begin
      s_next.rd_done = 1'b1;
      unique case (avs_address)
        `SLT_HC_CTRL_IDX:   s_next.readdata = {28'h0, s_reg.rnw, 1'b0, s_reg.sync_req, busy};
        `SLT_HC_ACCESS_IDX: s_next.readdata = {8'h00, s_reg.acc_wdata, s_reg.acc_addr};
        `SLT_HC_STATUS_IDX: s_next.readdata = {16'h0, s_reg.acc_rdata, 3'h0,
                                               link.lane_on != 4'h0, s_reg.step, busy};
        default:            s_next.readdata = s_reg.lanes;
      endcase
    end
    // Start and go are ignored while a sequence runs; other fields still update
    if (avs_write) begin
      unique case (avs_address)
        `SLT_HC_CTRL_IDX: begin
          s_next.sync_req = avs_writedata[`SLT_HC_SYNC_BIT];
          s_next.rnw = avs_writedata[`SLT_HC_RNW_BIT];
          if (!busy && avs_writedata[`SLT_HC_START_BIT]) begin
            s_next.st = SLT_HS_INIT;
            s_next.step = 3'd0;
          end else if (!busy && avs_writedata[`SLT_HC_GO_BIT]) begin
            s_next.st = SLT_HS_ONE;
          end
        end
        `SLT_HC_ACCESS_IDX: begin
          s_next.acc_addr = avs_writedata[15:0];
          s_next.acc_wdata = avs_writedata[23:16];
        end
        default: begin
        end
      endcase
    end
    unique case (s_reg.st)
      SLT_HS_IDLE: begin
      end
      SLT_HS_INIT: begin
        {s_next.addr, s_next.wdata} = init_step(s_reg.step);
        s_next.wr = 1'b1;
        s_next.st = SLT_HS_WAIT;
      end
      SLT_HS_ONE: begin
        s_next.addr = s_reg.acc_addr;
        s_next.wdata = s_reg.acc_wdata;
        s_next.wr = ~s_reg.rnw;
        s_next.rd = s_reg.rnw;
        s_next.step = `SLT_INIT_STEPS - 3'd1;
        s_next.st = SLT_HS_WAIT;
      end
      SLT_HS_WAIT: begin
        // Request held until the device acknowledges
        if (link.cfg_ack) begin
          s_next.wr = 1'b0;
          s_next.rd = 1'b0;
          if (s_reg.rd) begin
            s_next.acc_rdata = link.cfg_rdata;
          end
          if (s_reg.step == `SLT_INIT_STEPS - 3'd1) begin
            s_next.st = SLT_HS_IDLE;
          end else begin
            s_next.step = s_reg.step + 3'd1;
            s_next.st = SLT_HS_INIT;
          end
        end
      end
    endcase
    if (link.lane_strobe) begin
      s_next.lanes = link.lane_octet;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.st <= SLT_HS_IDLE;
      s_reg.sync_req <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.cfg_addr = s_reg.addr;
  assign link.cfg_wdata = s_reg.wdata;
  assign link.cfg_wr = s_reg.wr;
  assign link.cfg_rd = s_reg.rd;
  assign link.sync_request_input_n = ~s_reg.sync_req;
  assign avs_readdata = s_reg.readdata;
  assign avs_waitrequest = avs_read & ~s_reg.rd_done;
endmodule : slt_host

// ==== verification/slt_link_asserts.sv ====
// Checker for the register port and lanes joining the two ends.
// Assumes instantiation beside the link interface, one clock domain.
`timescale 1ns/1ps
`include "slt_defines.svh"
module slt_link_asserts (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // Register port
  input  wire logic [15:0]     cfg_addr,
  input  wire logic [7:0]      cfg_wdata,
  input  wire logic            cfg_wr,
  input  wire logic            cfg_rd,
  input  wire logic            cfg_ack,
  // Lanes
  input  wire logic [3:0][7:0] lane_octet,
  input  wire logic [3:0]      lane_k,
  input  wire logic [3:0]      lane_on,
  input  wire logic            lane_strobe,
  input  wire logic            sync_request_input_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic take;
  assign take = (cfg_wr | cfg_rd) & ~cfg_ack;
  sequence s_wr(a, d);
    take && cfg_wr && cfg_addr == a && cfg_wdata == d;
  endsequence
  sequence s_pll_tail;
    s_wr(16'h1222, 8'h00) ##[1:6] s_wr(16'h1262, 8'h08) ##[1:6] s_wr(16'h1262, 8'h00);
  endsequence
  property p_ack_one; cfg_ack |=> !cfg_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_take; take |=> cfg_ack; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked");
  property p_no_spur; !(cfg_wr || cfg_rd) |=> !cfg_ack; endproperty
  a_no_spur: assert property (p_no_spur) else $error("ack without request");
  property p_req_hold; take |=> (cfg_wr || cfg_rd) && $stable(cfg_addr) && $stable(cfg_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_sync_k;
    lane_strobe && !$past(sync_request_input_n) |->
      lane_k == 4'hf && lane_octet == {4{`SLT_K28_5}};
  endproperty
  a_sync_k: assert property (p_sync_k) else $error("data sent under sync request");
  property p_data_k; lane_strobe && $past(sync_request_input_n) |-> lane_k == 4'h0; endproperty
  a_data_k: assert property (p_data_k) else $error("control flag on data");
  property p_lanes_hold; !lane_strobe |-> $stable(lane_octet) && $stable(lane_k); endproperty
  a_lanes_hold: assert property (p_lanes_hold) else $error("octet moved off strobe");
  property p_init_head;
    s_wr(16'h1228, 8'h4f) |-> ##[1:6] s_wr(16'h1228, 8'h0f) ##[1:6] s_wr(16'h1222, 8'h00)
      ##[1:6] s_wr(16'h1222, 8'h04);
  endproperty
  a_init_head: assert property (p_init_head) else $error("init order broken");
  property p_init_tail; s_wr(16'h1222, 8'h04) |-> ##[1:6] s_pll_tail; endproperty
  a_init_tail: assert property (p_init_tail) else $error("init tail broken");
  property p_restart_off; take && cfg_wr && cfg_addr == 16'h0571 && cfg_wdata[0] |->
    ##[1:3] lane_on == 4'h0; endproperty
  a_restart_off: assert property (p_restart_off) else $error("lanes on in restart");
endmodule : slt_link_asserts

// ==== verification/tb_serial_link_tx_setup.sv ====
// Testbench: controller and device joined by the link, driven over Avalon.
// Assumes the design files and slt_defines.svh on the include path.
`timescale 1ns/1ps
`include "slt_defines.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_link_tx_setup;
  logic        sys_clk, rst_b, avs_read, avs_write, pll_locked, sysref_seen, sync_bit;
  logic        avs_waitrequest, deemph_en, pll_cal_reset, startup_reset;
  logic [13:0] sample_a, sample_b;
  logic [1:0]  avs_address, over_range;
  logic [31:0] avs_writedata, avs_readdata, rd, rng;
  logic [3:0]  lane_rate_code;
  logic [7:0]  mreg [int];
  logic [7:0]  rates [4] = '{8'h00, 8'h30, 8'h50, 8'h10};
  int          n_errors, num_checks, cyc, k, ones;
  slt_link_if link ();
  slt_device slt_device_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .sample_a(sample_a), .sample_b(sample_b), .over_range(over_range),
    .sysref_seen(sysref_seen), .fast_detect(2'b00), .pll_locked(pll_locked),
    .power_down_pin(1'b0), .deemph_en(deemph_en), .lane_rate_code(lane_rate_code),
    .pll_cal_reset(pll_cal_reset), .startup_reset(startup_reset));
  slt_host slt_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  slt_link_asserts slt_link_asserts_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata), .cfg_wr(link.cfg_wr),
    .cfg_rd(link.cfg_rd), .cfg_ack(link.cfg_ack), .lane_octet(link.lane_octet),
    .lane_k(link.lane_k), .lane_on(link.lane_on), .lane_strobe(link.lane_strobe),
    .sync_request_input_n(link.sync_request_input_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic void mreset();
    mreg = '{'h0002: 8'h00, 'h0201: 8'h01, 'h0561: 8'h00, 'h056e: 8'h10, 'h0570: 8'h00,
             'h0571: 8'h00, 'h05c4: 8'h00, 'h1222: 8'h00, 'h1228: 8'h0f, 'h1262: 8'h00};
  endfunction : mreset

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Holds the request until waitrequest is seen low at an edge
  task automatic av(input logic rnw, input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rnw;
    avs_write <= !rnw;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : av

  task automatic busy_wait;
    do av(1'b1, 2'd2, 32'h0); while (rd[0] !== 1'b0);
  endtask : busy_wait

  task automatic dev(input logic rnw, input logic [15:0] a, input logic [7:0] d);
    av(1'b0, 2'd1, {8'h00, d, a});
    av(1'b0, 2'd0, {28'h0, rnw, 1'b1, sync_bit, 1'b0});
    busy_wait();
  endtask : dev

  task automatic mwr(input logic [15:0] a, input logic [7:0] d);
    dev(1'b0, a, d);
    if (a == 16'h0000 && d == `SLT_SOFT_RESET_CODE) mreset();
    else if (mreg.exists(a)) mreg[a] = d;
  endtask : mwr

  task automatic mrd(input string nm, input logic [15:0] a);
    dev(1'b1, a, 8'h00);
    `CHK(nm, (mreg.exists(a) ? mreg[a] : 8'h00), rd[15:8])
  endtask : mrd

  task automatic init_run;
    av(1'b0, 2'd0, {28'h0, 2'b00, sync_bit, 1'b1});
    busy_wait();
    mreg[16'h1228] = 8'h0f;
    mreg[16'h1222] = 8'h00;
    mreg[16'h1262] = 8'h00;
  endtask : init_run

  task automatic lose_lock;
    pll_locked <= 1'b0;
    repeat (8) @(posedge sys_clk);
    pll_locked <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : lose_lock

  task automatic pll_chk(input logic [7:0] e);
    dev(1'b1, 16'h056f, 8'h00);
    `CHK("pll status", e, rd[15:8] & 8'h88)
  endtask : pll_chk

  task automatic frame_chk(input logic [1:0] cs, input logic ob);
    logic [13:0] a, b;
    logic [1:0]  tl_a, tl_b;
    a = sample_a ^ {ob, 13'h0};
    b = sample_b ^ {ob, 13'h0};
    tl_a = {cs != 2'd0 && over_range[0], cs >= 2'd2 && sysref_seen};
    tl_b = {cs != 2'd0 && over_range[1], cs >= 2'd2 && sysref_seen};
    `CHK("lane 0", a[13:6], link.lane_octet[0])
    `CHK("lane 1", {a[5:0], tl_a}, link.lane_octet[1])
    `CHK("lane 2", b[13:6], link.lane_octet[2])
    `CHK("lane 3", {b[5:0], tl_b}, link.lane_octet[3])
    av(1'b1, 2'd3, 32'h0);
    `CHK("lanes word", {b[5:0], tl_b, b[13:6], a[5:0], tl_a, a[13:6]}, rd)
  endtask : frame_chk

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Cuts a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'd0;
    avs_writedata = 32'h0;
    sample_a = 14'h0;
    sample_b = 14'h0;
    over_range = 2'b00;
    sysref_seen = 1'b0;
    pll_locked = 1'b0;
    sync_bit = 1'b1;
    rng = 32'h611d;
    mreset();
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK("lanes on", 4'hf, link.lane_on)
    `CHK("deemphasis", 1'b0, deemph_en)
    `CHK("rate code", 4'h1, lane_rate_code)
    `CHK("sync octets", {4{8'hbc}}, link.lane_octet)
    foreach (mreg[a]) mrd("reset value", 16'(a));
    mrd("unmapped", 16'h0003);
    foreach (rates[i]) begin
      mwr(16'h056e, rates[i]);
      mrd("lane rate", 16'h056e);
      `CHK("rate code", rates[i][7:4], lane_rate_code)
    end
    mwr(16'h05c4, 8'h01);
    `CHK("deemphasis", 1'b1, deemph_en)
    mwr(16'h0000, `SLT_SOFT_RESET_CODE);
    mrd("soft reset", 16'h05c4);
    init_run();
    mrd("startup", 16'h1228);
    mrd("pll ctrl", 16'h1222);
    `CHK("cal reset", 1'b0, pll_cal_reset)
    `CHK("startup reset", 1'b0, startup_reset)
    mwr(16'h0001, `SLT_DP_RESET_CODE);
    init_run();
    pll_locked <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pll_chk(8'h80);
    lose_lock();
    pll_chk(8'h88);
    mwr(16'h0571, 8'h01);
    mwr(16'h0571, 8'h00);
    pll_chk(8'h80);
    lose_lock();
    mwr(16'h1262, 8'h08);
    mwr(16'h1262, 8'h00);
    pll_chk(8'h80);
    mwr(16'h0002, 8'h02);
    av(1'b1, 2'd2, 32'h0);
    `CHK("lanes down", 1'b0, rd[4])
    mwr(16'h0570, 8'h00);
    mwr(16'h056e, 8'h10);
    mwr(16'h1228, 8'h40);
    `CHK("startup reset", 1'b1, startup_reset)
    mwr(16'h1222, 8'h0c);
    `CHK("cal reset", 1'b1, pll_cal_reset)
    mwr(16'h0002, 8'h00);
    init_run();
    `CHK("lanes up", 4'hf, link.lane_on)
    `CHK("startup reset", 1'b0, startup_reset)
    `CHK("cal reset", 1'b0, pll_cal_reset)
    sync_bit = 1'b0;
    av(1'b0, 2'd0, {28'h0, 4'b0000});
    for (int m = 0; m < 8; m++) begin
      mwr(16'h0570, {2'b00, 2'(m), 4'h0});
      mwr(16'h0561, {7'h0, m[2]});
      rng = xs(rng);
      sample_a <= rng[13:0];
      sample_b <= rng[29:16];
      over_range <= rng[31:30];
      sysref_seen <= rng[14];
      repeat (3) @(posedge sys_clk);
      frame_chk(2'(m), m[2]);
    end
    mwr(16'h0570, 8'h14);
    ones = 0;
    repeat (16) begin
      @(posedge sys_clk);
      ones += int'(link.lane_octet[1][0]);
    end
    `CHK("prn tail", 1'b1, ones > 0 && ones < 16)
    `CHK("ctl bit 2", over_range[0], link.lane_octet[1][1])
    mwr(16'h0201, 8'h03);
    do @(posedge sys_clk); while (link.lane_strobe !== 1'b1);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      rng = xs(rng);
      sample_a <= rng[13:0];
    end while (link.lane_strobe !== 1'b1 && k < 10);
    `CHK("strobe gap", 3, k)
    final_report();
  end
endmodule : tb_serial_link_tx_setup
